// >>> rtl/read_latency_lookup.sv
// Read opcode decode, latency lookup and mode/dummy sequencer.
// Assumes the command decoder strobes the opcode and the address end,
// and that MCLK_IN is the serial clock.
`timescale 1ns/1ps

module read_latency_lookup
(
   input  wire logic       MCLK_IN,
   input  wire logic       RST_B_IN,
   input  wire logic       CMD_VALID_IN,
   input  wire logic [7:0] CMD_OPCODE_IN,
   input  wire logic [1:0] LAT_CODE_IN,
   input  wire logic       ADDR_DONE_IN,
   input  wire logic       CS_END_IN,
   input  wire logic [6:0] TBL_ADDR_IN,
   output logic            CMD_HIT_OUT,
   output logic            ADDR4_OUT,
   output logic            UNSUP_OUT,
   output logic      [7:0] MODE_CNT_OUT,
   output logic      [7:0] DUMMY_CNT_OUT,
   output logic            MODE_PHASE_OUT,
   output logic            DUMMY_PHASE_OUT,
   output logic            DATA_START_OUT,
   output logic            DATA_PHASE_OUT,
   output logic      [7:0] TBL_DATA_OUT
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   read_latency_pkg::seq_state_t state_r;
   read_latency_pkg::seq_state_t state_nxt;

   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic       hit_r;
   logic       hit_nxt;
   logic       addr4_r;
   logic       addr4_nxt;
   logic       unsup_r;
   logic       unsup_nxt;
   logic [7:0] mode_r;
   logic [7:0] mode_nxt;
   logic [7:0] dummy_r;
   logic [7:0] dummy_nxt;
   logic       mode_ph_r;
   logic       dummy_ph_r;
   logic       data_ph_r;
   logic       start_r;
   logic       start_nxt;
   logic [7:0] tbl_r;

   logic [5:0] match3;
   logic [5:0] match4;
   logic       opc_ok;
   logic       opc_4b;
   logic [2:0] cmd_idx;
   logic [1:0] row_sel;
   logic [6:0] row_ofs;
   logic [6:0] mode_addr;
   logic [6:0] dummy_addr;
   logic [7:0] mode_byte;
   logic [7:0] dummy_byte;
   logic [7:0] tbl_byte;
   logic       cmd_take;

   // ----------------------------------------
   // Opcode match against the table header
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < read_latency_pkg::CMD_NUM; g++)
      begin : gen_opc
         localparam logic [6:0] OFS3 = read_latency_pkg::HDR_OPC_OFS + 7'(2 * g);
         assign match3[g] = CMD_OPCODE_IN == read_latency_pkg::LAT_TABLE[OFS3];
         assign match4[g] = CMD_OPCODE_IN == read_latency_pkg::LAT_TABLE[OFS3 + 7'h01];
      end
   endgenerate

   always_comb
   begin
      opc_ok  = 1'b0;
      opc_4b  = 1'b0;
      cmd_idx = 3'h0;
      for (int i = 0; i < read_latency_pkg::CMD_NUM; i++)
      begin
         if (match3[i] || match4[i])
         begin
            opc_ok  = 1'b1;
            opc_4b  = match4[i];
            cmd_idx = 3'(i);
         end
      end
   end

   // ----------------------------------------
   // Row select by latency code
   // ----------------------------------------
   always_comb
   begin
      case (LAT_CODE_IN)
         read_latency_pkg::LC_50:  row_sel = 2'h0;
         read_latency_pkg::LC_80:  row_sel = 2'h1;
         read_latency_pkg::LC_90:  row_sel = 2'h2;
         read_latency_pkg::LC_104: row_sel = 2'h3;
         default:                  row_sel = 2'h0;
      endcase
   end

   assign row_ofs    = read_latency_pkg::ROW_BASE + 7'(read_latency_pkg::ROW_LEN * row_sel);
   assign mode_addr  = row_ofs + 7'h02 + {3'h0, cmd_idx, 1'b0};
   assign dummy_addr = mode_addr + 7'h01;

   latency_cycle_table u_mode_tbl
   (
      .addr_in  (mode_addr),
      .data_out (mode_byte)
   );

   latency_cycle_table u_dummy_tbl
   (
      .addr_in  (dummy_addr),
      .data_out (dummy_byte)
   );

   latency_cycle_table u_host_tbl
   (
      .addr_in  (TBL_ADDR_IN),
      .data_out (tbl_byte)
   );

   assign cmd_take = (state_r == read_latency_pkg::ST_IDLE) && CMD_VALID_IN && !CS_END_IN;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      hit_nxt   = hit_r;
      addr4_nxt = addr4_r;
      unsup_nxt = unsup_r;
      mode_nxt  = mode_r;
      dummy_nxt = dummy_r;
      start_nxt = 1'b0;
      if (CS_END_IN)
      begin
         state_nxt = read_latency_pkg::ST_IDLE;
         hit_nxt   = 1'b0;
         cnt_nxt   = 8'h00;
      end
      else
      begin
         case (state_r)
            read_latency_pkg::ST_IDLE:
            begin
               if (CMD_VALID_IN)
               begin
                  hit_nxt   = opc_ok;
                  addr4_nxt = opc_ok && opc_4b;
                  mode_nxt  = opc_ok ? mode_byte : 8'h00;
                  dummy_nxt = opc_ok ? dummy_byte : 8'h00;
                  unsup_nxt = opc_ok && (mode_byte == read_latency_pkg::NOT_SUPP);
                  if (opc_ok && (mode_byte != read_latency_pkg::NOT_SUPP))
                  begin
                     state_nxt = read_latency_pkg::ST_ADDR;
                  end
                  else
                  begin
                     hit_nxt = 1'b0;
                  end
               end
            end
            read_latency_pkg::ST_ADDR:
            begin
               if (ADDR_DONE_IN)
               begin
                  if (mode_r != 8'h00)
                  begin
                     state_nxt = read_latency_pkg::ST_MODE;
                     cnt_nxt   = mode_r - 8'h01;
                  end
                  else if (dummy_r != 8'h00)
                  begin
                     state_nxt = read_latency_pkg::ST_DUMMY;
                     cnt_nxt   = dummy_r - 8'h01;
                  end
                  else
                  begin
                     state_nxt = read_latency_pkg::ST_DATA;
                     start_nxt = 1'b1;
                  end
               end
            end
            read_latency_pkg::ST_MODE:
            begin
               if (cnt_r != 8'h00)
               begin
                  cnt_nxt = cnt_r - 8'h01;
               end
               else if (dummy_r != 8'h00)
               begin
                  state_nxt = read_latency_pkg::ST_DUMMY;
                  cnt_nxt   = dummy_r - 8'h01;
               end
               else
               begin
                  state_nxt = read_latency_pkg::ST_DATA;
                  start_nxt = 1'b1;
               end
            end
            read_latency_pkg::ST_DUMMY:
            begin
               if (cnt_r != 8'h00)
               begin
                  cnt_nxt = cnt_r - 8'h01;
               end
               else
               begin
                  state_nxt = read_latency_pkg::ST_DATA;
                  start_nxt = 1'b1;
               end
            end
            read_latency_pkg::ST_DATA:
            begin
               state_nxt = read_latency_pkg::ST_DATA;
            end
            default:
            begin
               state_nxt = read_latency_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         state_r    <= read_latency_pkg::ST_IDLE;
         cnt_r      <= 8'h00;
         hit_r      <= 1'b0;
         addr4_r    <= 1'b0;
         unsup_r    <= 1'b0;
         mode_r     <= 8'h00;
         dummy_r    <= 8'h00;
         mode_ph_r  <= 1'b0;
         dummy_ph_r <= 1'b0;
         data_ph_r  <= 1'b0;
         start_r    <= 1'b0;
         tbl_r      <= 8'h00;
      end
      else
      begin
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         hit_r      <= hit_nxt;
         addr4_r    <= addr4_nxt;
         unsup_r    <= unsup_nxt;
         mode_r     <= mode_nxt;
         dummy_r    <= dummy_nxt;
         mode_ph_r  <= state_nxt == read_latency_pkg::ST_MODE;
         dummy_ph_r <= state_nxt == read_latency_pkg::ST_DUMMY;
         data_ph_r  <= state_nxt == read_latency_pkg::ST_DATA;
         start_r    <= start_nxt;
         tbl_r      <= tbl_byte;
      end
   end

   assign CMD_HIT_OUT     = hit_r;
   assign ADDR4_OUT       = addr4_r;
   assign UNSUP_OUT       = unsup_r;
   assign MODE_CNT_OUT    = mode_r;
   assign DUMMY_CNT_OUT   = dummy_r;
   assign MODE_PHASE_OUT  = mode_ph_r;
   assign DUMMY_PHASE_OUT = dummy_ph_r;
   assign DATA_START_OUT  = start_r;
   assign DATA_PHASE_OUT  = data_ph_r;
   assign TBL_DATA_OUT    = tbl_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   AST_TBL_ID: assert property (TBL_ADDR_IN == 7'h00 |=> TBL_DATA_OUT == 8'h90)
      else $error("table id wrong");
   AST_TBL_SHAPE: assert property (TBL_ADDR_IN == 7'h02 ##1 TBL_ADDR_IN == 7'h03
      |-> TBL_DATA_OUT == 8'h06 ##1 TBL_DATA_OUT == 8'h0E)
      else $error("table shape wrong");
   AST_RD4: assert property (cmd_take && LAT_CODE_IN == 2'h3 && CMD_OPCODE_IN == 8'h13 |=> CMD_HIT_OUT && ADDR4_OUT)
      else $error("normal read 4-byte not decoded");
   AST_FR4: assert property (cmd_take && CMD_OPCODE_IN == 8'h0C |=> CMD_HIT_OUT && ADDR4_OUT)
      else $error("fast read 4-byte not decoded");
   AST_DO4: assert property (cmd_take && CMD_OPCODE_IN == 8'h3C |=> CMD_HIT_OUT && ADDR4_OUT)
      else $error("dual out 4-byte not decoded");
   AST_QO3: assert property (cmd_take && CMD_OPCODE_IN == 8'h6B |=> CMD_HIT_OUT && !ADDR4_OUT)
      else $error("quad out 3-byte not decoded");
   AST_DIO4: assert property (cmd_take && CMD_OPCODE_IN == 8'hBC |=> CMD_HIT_OUT && ADDR4_OUT)
      else $error("dual io 4-byte not decoded");
   AST_QIO3: assert property (cmd_take && CMD_OPCODE_IN == 8'hEB |=> CMD_HIT_OUT && !ADDR4_OUT)
      else $error("quad io 3-byte not decoded");
   AST_CODE50: assert property (TBL_ADDR_IN == 7'h13 |=> TBL_DATA_OUT == 8'h03)
      else $error("50 MHz row code wrong");
   AST_CODE80: assert property (TBL_ADDR_IN == 7'h21 |=> TBL_DATA_OUT == 8'h00)
      else $error("80 MHz row code wrong");
   AST_CODE90: assert property (TBL_ADDR_IN == 7'h2F |=> TBL_DATA_OUT == 8'h01)
      else $error("90 MHz row code wrong");
   AST_L50_PLAIN: assert property (cmd_take && LAT_CODE_IN == 2'h3 && CMD_OPCODE_IN == 8'h6C
      |=> MODE_CNT_OUT == 8'h00 && DUMMY_CNT_OUT == 8'h00)
      else $error("quad out latency at code 11b wrong");
   AST_L50_DIO: assert property (cmd_take && LAT_CODE_IN == 2'h3 && CMD_OPCODE_IN == 8'hBB
      |=> MODE_CNT_OUT == 8'h00 && DUMMY_CNT_OUT == 8'h04)
      else $error("dual io latency at code 11b wrong");
   AST_L50_QIO: assert property (cmd_take && LAT_CODE_IN == 2'h3 && CMD_OPCODE_IN == 8'hEC
      |=> MODE_CNT_OUT == 8'h02 && DUMMY_CNT_OUT == 8'h01)
      else $error("quad io latency at code 11b wrong");
   AST_L80_FAST: assert property (cmd_take && LAT_CODE_IN == 2'h0 && CMD_OPCODE_IN == 8'h0B
      |=> MODE_CNT_OUT == 8'h00 && DUMMY_CNT_OUT == 8'h08)
      else $error("fast read latency at code 00b wrong");
   AST_L80_DO: assert property (cmd_take && LAT_CODE_IN == 2'h0 && CMD_OPCODE_IN == 8'h3B
      |=> DUMMY_CNT_OUT == 8'h08 && !UNSUP_OUT)
      else $error("dual out latency at code 00b wrong");
   AST_SEQ_QIO: assert property (disable iff (!RST_B_IN || CS_END_IN)
      state_r == read_latency_pkg::ST_ADDR && ADDR_DONE_IN && mode_r == 8'h02 && dummy_r == 8'h01
      |=> MODE_PHASE_OUT [*2] ##1 DUMMY_PHASE_OUT && !MODE_PHASE_OUT ##1 DATA_START_OUT)
      else $error("mode then dummy sequence wrong");
   AST_SEQ_ZERO: assert property (state_r == read_latency_pkg::ST_ADDR && ADDR_DONE_IN
      && !CS_END_IN && mode_r == 8'h00 && dummy_r == 8'h00
      |=> DATA_START_OUT && DATA_PHASE_OUT && !DUMMY_PHASE_OUT)
      else $error("zero latency data start late");

   COV_QIO: cover property (MODE_PHASE_OUT ##1 MODE_PHASE_OUT ##1 DUMMY_PHASE_OUT ##1 DATA_START_OUT);
   COV_DUMMY8: cover property (DUMMY_CNT_OUT == 8'h08 && DATA_START_OUT);
   COV_UNSUP: cover property (UNSUP_OUT);
   COV_ABORT: cover property (MODE_PHASE_OUT ##1 CS_END_IN);

endmodule

// >>> rtl/read_latency_pkg.sv
// Constants for the single-data-rate read latency lookup and its table.
// Assumes one serial clock; every rising clock edge is one serial clock cycle.
//
// How it works
// - A self-description table with id 90h, five rows of fourteen bytes, is readable byte by byte.
// - Normal read is opcode 03h with 3-byte and 13h with 4-byte address.
// - Fast read is opcode 0Bh with 3-byte and 0Ch with 4-byte address.
// - Dual-output read is opcode 3Bh with 3-byte and 3Ch with 4-byte address.
// - Quad-output read is opcode 6Bh with 3-byte and 6Ch with 4-byte address.
// - Dual I/O read is opcode BBh with 3-byte and BCh with 4-byte address.
// - Quad I/O read is opcode EBh with 3-byte and ECh with 4-byte address.
// - Latency code 11b serves a serial clock up to 50 MHz.
// - With code 11b normal, fast, dual-out and quad-out reads take no mode and no dummy cycles.
// - With code 11b the dual I/O read takes no mode cycles and four dummy cycles.
// - With code 11b the quad I/O read takes two mode cycles then one dummy cycle.
// - Latency code 00b serves a serial clock up to 80 MHz.
// - With code 00b the fast read takes no mode cycles.
// - With code 00b fast, dual-out and quad-out reads take eight dummy cycles.
// - Latency code 01b serves a serial clock up to 90 MHz.

package read_latency_pkg;

   // ----------------------------------------
   // Opcodes
   // ----------------------------------------
   localparam logic [7:0] OPC_RD3  = 8'h03;
   localparam logic [7:0] OPC_RD4  = 8'h13;
   localparam logic [7:0] OPC_FR3  = 8'h0B;
   localparam logic [7:0] OPC_FR4  = 8'h0C;
   localparam logic [7:0] OPC_DO3  = 8'h3B;
   localparam logic [7:0] OPC_DO4  = 8'h3C;
   localparam logic [7:0] OPC_QO3  = 8'h6B;
   localparam logic [7:0] OPC_QO4  = 8'h6C;
   localparam logic [7:0] OPC_DIO3 = 8'hBB;
   localparam logic [7:0] OPC_DIO4 = 8'hBC;
   localparam logic [7:0] OPC_QIO3 = 8'hEB;
   localparam logic [7:0] OPC_QIO4 = 8'hEC;

   // ----------------------------------------
   // Table layout
   // ----------------------------------------
   localparam int         TBL_BYTES   = 88;
   localparam int         CMD_NUM     = 6;
   localparam logic [6:0] HDR_OPC_OFS = 7'h06;
   localparam logic [6:0] ROW_BASE    = 7'h12;
   localparam logic [6:0] ROW_LEN     = 7'h0E;
   localparam logic [7:0] NOT_SUPP    = 8'hFF;
   localparam logic [1:0] LC_50       = 2'h3;
   localparam logic [1:0] LC_80       = 2'h0;
   localparam logic [1:0] LC_90       = 2'h1;
   localparam logic [1:0] LC_104      = 2'h2;

   localparam logic [7:0] LAT_TABLE [0:TBL_BYTES-1] = '{
      8'h90, 8'h56, 8'h06, 8'h0E, 8'h46, 8'h43, OPC_RD3, OPC_RD4,
      OPC_FR3, OPC_FR4, OPC_DO3, OPC_DO4, OPC_QO3, OPC_QO4, OPC_DIO3, OPC_DIO4,
      OPC_QIO3, OPC_QIO4, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h01,
      8'h50, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h08,
      8'h00, 8'h08, 8'h00, 8'h04, 8'h02, 8'h04, 8'h5A, 8'h01,
      8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08,
      8'h00, 8'h05, 8'h02, 8'h04, 8'h68, 8'h02, 8'hFF, 8'hFF,
      8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h06,
      8'h02, 8'h05, 8'h85, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_MODE,
      ST_DUMMY,
      ST_DATA
   } seq_state_t;

endpackage

// >>> rtl/latency_cycle_table.sv
// Byte-wide read-only view of the latency description table.
// Assumes a combinational use; the caller registers the byte.
`timescale 1ns/1ps

module latency_cycle_table
(
   input  wire logic [6:0] addr_in,
   output logic      [7:0] data_out
);

   always_comb
   begin
      if (int'(addr_in) < read_latency_pkg::TBL_BYTES)
      begin
         data_out = read_latency_pkg::LAT_TABLE[addr_in];
      end
      else
      begin
         data_out = 8'h00;
      end
   end

endmodule

// >>> dv/spi_host_model.sv
// Host side model: issues one read command and counts the wait it sees.
// Assumes the lookup block takes its inputs on the rising edge of clk_in.
`timescale 1ns/1ps

module spi_host_model
(
   input  wire logic       clk_in,
   input  wire logic       mode_ph_in,
   input  wire logic       dummy_ph_in,
   input  wire logic       start_in,
   input  wire logic       data_ph_in,
   input  wire logic       hit_in,
   output logic            cmd_valid_out,
   output logic      [7:0] opcode_out,
   output logic      [1:0] lat_out,
   output logic            addr_done_out,
   output logic            cs_end_out
);
   int   mode_n;
   int   dummy_n;
   int   wait_n;
   logic late_mode;
   logic held;
   logic hit_seen;
   logic quiet;

   initial
   begin
      cmd_valid_out = 1'b0;
      opcode_out    = 8'h00;
      lat_out       = 2'h3;
      addr_done_out = 1'b0;
      cs_end_out    = 1'b0;
   end

   // ---------------------------------------------
   // One command, abort deselects after the address
   // ---------------------------------------------
   task automatic run(input logic [7:0] opc, input logic [1:0] lat, input int adr_n, input int dat_n,
                      input bit abort, input bit bad);
      {mode_n, dummy_n, wait_n} = '0;
      {late_mode, held, hit_seen, quiet} = '0;
      if (!bad && (opc == 8'h03 || opc == 8'h13) && lat != 2'h3) return;
      @(negedge clk_in);
      cmd_valid_out = 1'b1;
      opcode_out    = opc;
      lat_out       = lat;
      @(negedge clk_in);
      cmd_valid_out = 1'b0;
      opcode_out    = ~opc;
      lat_out       = ~lat;
      hit_seen      = hit_in;
      repeat (adr_n - 1) @(negedge clk_in);
      addr_done_out = 1'b1;
      @(negedge clk_in);
      addr_done_out = 1'b0;
      if (!abort)
      begin
         while (!start_in && wait_n < 40)
         begin
            if (mode_ph_in && dummy_n > 0)
               late_mode = 1'b1;
            mode_n  += mode_ph_in;
            dummy_n += dummy_ph_in;
            wait_n++;
            @(negedge clk_in);
         end
         held = start_in & data_ph_in;
         for (int n = 0; n < dat_n; n++)
         begin
            cmd_valid_out = (n == 0);
            opcode_out    = 8'hEB;
            lat_out       = 2'h0;
            @(negedge clk_in);
            held &= data_ph_in & ~start_in & hit_in;
         end
         cmd_valid_out = 1'b0;
      end
      cs_end_out = 1'b1;
      @(negedge clk_in);
      cs_end_out = 1'b0;
      quiet      = ~(hit_in | mode_ph_in | dummy_ph_in | start_in | data_ph_in);
   endtask
endmodule

// >>> dv/read_latency_lookup_test.sv
// Self-checking bench for the read latency lookup.
// Assumes the host model in spi_host_model drives the command inputs.
`timescale 1ns/1ps

module read_latency_lookup_test;
   localparam logic [7:0] opc_list [0:11] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C,
                                              8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC};
   localparam logic [7:0] hdr_list [0:5]  = '{8'h90, 8'h56, 8'h06, 8'h0E, 8'h46, 8'h43};
   localparam logic [7:0] row_list [0:9]  = '{8'h32, 8'h03, 8'h50, 8'h00, 8'h5A, 8'h01,
                                              8'h68, 8'h02, 8'h85, 8'h02};
   logic        mclk     = 1'b0;
   logic        rst_b    = 1'b0;
   logic  [6:0] tbl_addr = 7'h00;
   logic        cmd_valid, addr_done, cs_end, hit, addr4, unsup_o;
   logic        mph, yph, dstart, dph;
   logic  [7:0] opcode, mode_cnt, dummy_cnt, tbl_data, opc;
   logic  [1:0] lat, code;
   logic [15:0] e;
   int          seed     = 32'hA4DE6442;
   int          failures = 0;
   int          compares = 0;
   int          cycles   = 0;
   bit          idle, unsup, ab;

   read_latency_lookup dut_u (.MCLK_IN(mclk), .RST_B_IN(rst_b), .CMD_VALID_IN(cmd_valid), .CMD_OPCODE_IN(opcode),
      .LAT_CODE_IN(lat), .ADDR_DONE_IN(addr_done), .CS_END_IN(cs_end), .TBL_ADDR_IN(tbl_addr),
      .CMD_HIT_OUT(hit), .ADDR4_OUT(addr4), .UNSUP_OUT(unsup_o), .MODE_CNT_OUT(mode_cnt),
      .DUMMY_CNT_OUT(dummy_cnt), .MODE_PHASE_OUT(mph), .DUMMY_PHASE_OUT(yph), .DATA_START_OUT(dstart),
      .DATA_PHASE_OUT(dph), .TBL_DATA_OUT(tbl_data));

   spi_host_model host_u (.clk_in(mclk), .mode_ph_in(mph), .dummy_ph_in(yph), .start_in(dstart),
      .data_ph_in(dph), .hit_in(hit), .cmd_valid_out(cmd_valid), .opcode_out(opcode), .lat_out(lat),
      .addr_done_out(addr_done), .cs_end_out(cs_end));

   // ---------------------------------------------
   // Expected values
   // ---------------------------------------------
   function automatic logic [15:0] lat_exp(input int i, input logic [1:0] c);
      if (i == 0 && c != 2'h3) return 16'hFFFF;
      if (i == 5) return {8'h02, (c == 2'h3) ? 8'h01 : (c == 2'h2) ? 8'h05 : 8'h04};
      if (c == 2'h3) return (i == 4) ? 16'h0004 : 16'h0000;
      if (i == 4) return {8'h00, (c == 2'h0) ? 8'h04 : (c == 2'h1) ? 8'h05 : 8'h06};
      return 16'h0008;
   endfunction

   function automatic logic [7:0] tbl_exp(input int a);
      int          r;
      int          k;
      logic [15:0] v;
      if (a < 6) return hdr_list[a];
      if (a < 18) return opc_list[a - 6];
      if (a >= 88) return 8'h00;
      r = (a - 18) / 14;
      k = (a - 18) % 14;
      if (k < 2) return row_list[r * 2 + k];
      if (r == 4) return (k == 4) ? 8'h00 : (k == 5) ? 8'h08 : 8'hFF;
      v = lat_exp((k - 2) / 2, row_list[r * 2 + 1][1:0]);
      return k[0] ? v[7:0] : v[15:8];
   endfunction

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report;
      if (failures == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      forever #25 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         final_report;
      end
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      @(negedge mclk);
      check("idle after reset", {hit, mph, yph, dph}, 8'h00);
      for (int i = 0; i < 200; i++)
      begin
         tbl_addr = (i < 128) ? i[6:0] : 7'($unsigned($random(seed)) % 128);
         @(negedge mclk);
         check("table byte", tbl_data, tbl_exp(int'(tbl_addr)));
      end
      for (int c = 0; c < 4; c++)
      begin
         for (int i = 0; i < 13; i++)
         begin
            code = c[1:0];
            opc  = (i < 12) ? opc_list[i] : 8'h00;
            if (i == 12)
               do opc = 8'($random(seed)); while (opc inside {opc_list});
            e     = (i < 12) ? lat_exp(i / 2, code) : 16'h0000;
            unsup = (i < 2 && code != 2'h3);
            idle  = unsup || i == 12;
            ab    = idle || ($unsigned($random(seed)) % 5 == 0);
            host_u.run(opc, code, $unsigned($random(seed)) % 4 + 1, $unsigned($random(seed)) % 4 + 1, ab, unsup);
            check("command hit", host_u.hit_seen, !idle);
            check("unsupported flag", unsup_o, unsup);
            check("released", host_u.quiet, 1'b1);
            if (!unsup)
            begin
               check("four byte form", addr4, (i < 12) && i[0]);
               check("mode count", mode_cnt, e[15:8]);
               check("dummy count", dummy_cnt, e[7:0]);
            end
            if (!ab)
            begin
               check("mode cycles", host_u.mode_n[7:0], e[15:8]);
               check("dummy cycles", host_u.dummy_n[7:0], e[7:0]);
               check("wait cycles", host_u.wait_n[7:0], e[15:8] + e[7:0]);
               check("phase order", {host_u.late_mode, host_u.held}, 8'h01);
            end
         end
      end
      final_report;
   end
endmodule
